// ===== hdl/adc_cal_defines.svh
`ifndef ADC_CAL_DEFINES_SVH
`define ADC_CAL_DEFINES_SVH

// clock and timing
`define CLK_PERIOD_NS 4
`define TRACK_TIME_NS 300
`define TRACK_CYCLES ((`TRACK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_CYCLES 4

// converter and arithmetic widths
`define SAR_WIDTH 12
`define SUM_WIDTH 18
`define AVG_CNT_W 6
`define REM_W 7
`define STEP_W 5
`define DIV_LAST_STEP 5'h11
`define IRQ_W 2
`define APB_ADDR_W 12

// register indices, byte address is four times the index
`define CAL_CTRL_IDX 8'hf5
`define IRQ_STATUS_IDX 8'hf6
`define IRQ_MASK_IDX 8'hf7
`define CONV_CTRL_IDX 8'hf8
`define CONV_RESULT_IDX 8'hf9
`define OFFSET_COEF_IDX 8'hfa
`define GAIN_COEF_IDX 8'hfb

// calibration control fields
`define CAL_CTRL_RESET 8'h00
`define BUSY_BIT 7
`define GAIN_DIS_BIT 6
`define AVG_HI_BIT 5
`define AVG_LO_BIT 4
`define CAL_ARM_BIT 2
`define CAL_TYPE_BIT 1
`define CAL_START_BIT 0

// averaging counts per select code
`define AVG_COUNT_00 6'h0f
`define AVG_COUNT_01 6'h01
`define AVG_COUNT_10 6'h1f
`define AVG_COUNT_11 6'h3f

// interrupt and conversion control fields
`define IRQ_CAL_DONE_BIT 0
`define IRQ_CONV_DONE_BIT 1
`define CONV_START_BIT 0

`endif

// ===== hdl/adc_cal_pkg.sv
`include "adc_cal_defines.svh"

package adc_cal_pkg;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_CONV = 3'b001,
      ST_CAL_RUN = 3'b010,
      ST_CAL_DIV = 3'b011,
      ST_FINISH = 3'b100
   } ctrl_state_t;

   typedef enum logic [1:0]
   {
      SAR_IDLE = 2'b00,
      SAR_TRACK = 2'b01,
      SAR_TRIAL = 2'b10
   } sar_phase_t;

   typedef struct packed {
      ctrl_state_t state;
      logic gain_dis;
      logic [1:0] avg_sel;
      logic cal_arm;
      logic cal_type;
      logic cal_start;
      logic busy;
      logic ref_sel;
      logic cal_active;
      logic conv_req;
      logic [`AVG_CNT_W-1:0] reads;
      logic [`SUM_WIDTH-1:0] sum;
      logic [`REM_W-1:0] rem;
      logic [`STEP_W-1:0] steps;
      logic [`SAR_WIDTH-1:0] result;
      logic [`SAR_WIDTH-1:0] offset_coef;
      logic [`SAR_WIDTH-1:0] gain_coef;
      logic [`IRQ_W-1:0] irq_status;
      logic [`IRQ_W-1:0] irq_mask;
      logic irq;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } ctrl_regs_t;

endpackage

// ===== hdl/sar_converter.sv
`timescale 1ns/1ns
`include "adc_cal_defines.svh"

module sar_converter
   import adc_cal_pkg::*;
#(
   parameter int unsigned WIDTH = `SAR_WIDTH,
   parameter int unsigned TRACK_CYCLES = `TRACK_CYCLES,
   parameter int unsigned SETTLE_CYCLES = `SETTLE_CYCLES
)
(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic start_in,
   input wire logic cmp_in,
   output logic track_out,
   output logic [WIDTH-1:0] code_out,
   output logic [WIDTH-1:0] result_out,
   output logic done_out
);

   localparam int unsigned CNT_W = $clog2(TRACK_CYCLES + SETTLE_CYCLES + 1);
   localparam int unsigned IDX_W = $clog2(WIDTH);

   typedef struct packed {
      sar_phase_t phase;
      logic [CNT_W-1:0] cnt;
      logic [IDX_W-1:0] bit_idx;
      logic [WIDTH-1:0] code;
      logic [WIDTH-1:0] result;
      logic done;
      logic track;
      logic s1;
      logic s2;
      logic s3;
      logic cmp_f;
   } sar_regs_t;

   sar_regs_t q;
   sar_regs_t d;

   always_comb
   begin
      logic [WIDTH-1:0] trial;
      trial = q.code;
      d = q;
      d.done = 1'b0;
      // comparator is asynchronous to the clock; settle time must cover the filter delay
      d.s1 = cmp_in;
      d.s2 = q.s1;
      d.s3 = q.s2;
      if (q.s2 == q.s3)
      begin
         d.cmp_f = q.s3;
      end
      case (q.phase)
         SAR_IDLE:
         begin
            if (start_in)
            begin
               d.phase = SAR_TRACK;
               d.track = 1'b1;
               d.cnt = '0;
               d.code = '0;
            end
         end
         SAR_TRACK:
         begin
            if (q.cnt == CNT_W'(TRACK_CYCLES - 1))
            begin
               d.phase = SAR_TRIAL;
               d.track = 1'b0;
               d.cnt = '0;
               d.bit_idx = IDX_W'(WIDTH - 1);
               d.code = {1'b1, {(WIDTH-1){1'b0}}};
            end
            else
            begin
               d.cnt = q.cnt + 1'b1;
            end
         end
         SAR_TRIAL:
         begin
            if (q.cnt == CNT_W'(SETTLE_CYCLES - 1))
            begin
               // decide on the value the filter agrees on this cycle, saving a settle cycle
               if (!d.cmp_f)
               begin
                  trial[q.bit_idx] = 1'b0;
               end
               d.cnt = '0;
               if (q.bit_idx == '0)
               begin
                  d.result = trial;
                  d.done = 1'b1;
                  d.phase = SAR_IDLE;
               end
               else
               begin
                  trial[q.bit_idx - 1'b1] = 1'b1;
                  d.bit_idx = q.bit_idx - 1'b1;
               end
               d.code = trial;
            end
            else
            begin
               d.cnt = q.cnt + 1'b1;
            end
         end
         default:
         begin
            d.phase = SAR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign track_out = q.track;
   assign code_out = q.code;
   assign result_out = q.result;
   assign done_out = q.done;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);

   sequence s_last_trial;
      q.phase == SAR_TRIAL && q.bit_idx == '0 && q.cnt == CNT_W'(SETTLE_CYCLES - 1);
   endsequence

   property p_start_tracks;
      (q.phase == SAR_IDLE && start_in) |=> q.track && q.phase == SAR_TRACK;
   endproperty
   a_start_tracks: assert property (p_start_tracks) else $error("track did not begin");

   property p_track_length;
      $fell(q.track) |-> $past(q.cnt) == CNT_W'(TRACK_CYCLES - 1) && q.phase == SAR_TRIAL;
   endproperty
   a_track_length: assert property (p_track_length) else $error("track phase wrong length");

   property p_result_latched;
      s_last_trial |=> q.done && q.result == q.code && q.phase == SAR_IDLE && !q.track;
   endproperty
   a_result_latched: assert property (p_result_latched) else $error("result not latched");

endmodule

// ===== hdl/adc_calibration_control.sv
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`include "adc_cal_defines.svh"

// Behaviour
// - busy reads high during any conversion or calibration, clears itself at the end
// - gain calibration runs when disable bit is 0, is skipped when 1
// - calibration averages 15, 1, 31 or 63 readings per select code 00..11
// - type bit 0 selects offset calibration, 1 selects gain calibration
// - software sets start bit to calibrate; hardware clears it on completion
// - each conversion tracks, then holds; timed internally; final code latched as result
// - calibration control sits at index f5, resets to 00, not bit addressable
module adc_calibration_control
   import adc_cal_pkg::*;
#(
   parameter int unsigned TRACK_CYCLES = `TRACK_CYCLES,
   parameter int unsigned SETTLE_CYCLES = `SETTLE_CYCLES
)
(
   input wire logic clock_in,
   input wire logic sys_rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [`APB_ADDR_W-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic irq_out,
   input wire logic cmp_in,
   output logic track_out,
   output logic [`SAR_WIDTH-1:0] sar_code_out,
   output logic ref_sel_out,
   output logic cal_active_out
);

   localparam logic [9:0] A_CTRL = {2'b00, `CAL_CTRL_IDX};
   localparam logic [9:0] A_STATUS = {2'b00, `IRQ_STATUS_IDX};
   localparam logic [9:0] A_MASK = {2'b00, `IRQ_MASK_IDX};
   localparam logic [9:0] A_CONV = {2'b00, `CONV_CTRL_IDX};
   localparam logic [9:0] A_RESULT = {2'b00, `CONV_RESULT_IDX};
   localparam logic [9:0] A_OFFSET = {2'b00, `OFFSET_COEF_IDX};
   localparam logic [9:0] A_GAIN = {2'b00, `GAIN_COEF_IDX};

   ctrl_regs_t q;
   ctrl_regs_t d;
   logic sar_done;
   logic [`SAR_WIDTH-1:0] sar_result;
   logic [9:0] word_idx;
   logic setup;
   logic apb_wr;
   logic hit_ctrl;
   logic cal_take;
   logic conv_take;
   logic [7:0] ctrl_byte;

   function automatic logic [`AVG_CNT_W-1:0] avg_count(input logic [1:0] sel);
      case (sel)
         2'b00: avg_count = `AVG_COUNT_00;
         2'b01: avg_count = `AVG_COUNT_01;
         2'b10: avg_count = `AVG_COUNT_10;
         default: avg_count = `AVG_COUNT_11;
      endcase
   endfunction

   sar_converter #(
      .WIDTH(`SAR_WIDTH),
      .TRACK_CYCLES(TRACK_CYCLES),
      .SETTLE_CYCLES(SETTLE_CYCLES)
   ) u_sar (
      .clock_in(clock_in),
      .sys_rst_in(sys_rst_in),
      .start_in(q.conv_req),
      .cmp_in(cmp_in),
      .track_out(track_out),
      .code_out(sar_code_out),
      .result_out(sar_result),
      .done_out(sar_done)
   );

   assign word_idx = paddr_in[`APB_ADDR_W-1:2];
   assign setup = psel_in & ~penable_in;
   // a write lands only at the access edge of a decoded address
   assign apb_wr = psel_in & penable_in & q.pready & pwrite_in & ~q.pslverr;
   assign hit_ctrl = apb_wr & (word_idx == A_CTRL);
   // control writes are ignored while a cycle runs, so settings cannot shift mid-calibration
   assign cal_take = hit_ctrl & (q.state == ST_IDLE) & pwdata_in[`CAL_START_BIT];
   assign conv_take = apb_wr & (word_idx == A_CONV) & (q.state == ST_IDLE)
                      & pwdata_in[`CONV_START_BIT];
   // reserved bit 3 always reads zero
   assign ctrl_byte = {q.busy, q.gain_dis, q.avg_sel, 1'b0, q.cal_arm, q.cal_type,
                       q.cal_start};

   always_comb
   begin
      logic [31:0] rdata;
      logic hit;
      logic [`IRQ_W-1:0] ev;
      logic [`IRQ_W-1:0] clr;
      logic [`REM_W-1:0] rem_sh;
      logic [`REM_W-1:0] div;
      logic qbit;
      rdata = 32'h00000000;
      hit = 1'b1;
      ev = '0;
      clr = '0;
      rem_sh = {q.rem[`REM_W-2:0], q.sum[`SUM_WIDTH-1]};
      div = {1'b0, avg_count(q.avg_sel)};
      qbit = 1'b0;
      d = q;
      d.conv_req = 1'b0;

      // read data is captured in the setup cycle, answered in the first access cycle
      case (word_idx)
         A_CTRL: rdata = {24'h000000, ctrl_byte};
         A_STATUS: rdata = {30'h00000000, q.irq_status};
         A_MASK: rdata = {30'h00000000, q.irq_mask};
         A_CONV: rdata = {31'h00000000, q.state == ST_CONV};
         A_RESULT: rdata = {20'h00000, q.result};
         A_OFFSET: rdata = {20'h00000, q.offset_coef};
         A_GAIN: rdata = {20'h00000, q.gain_coef};
         default: hit = 1'b0;
      endcase
      d.pready = setup;
      d.pslverr = setup & ~hit;
      if (setup)
      begin
         d.prdata = hit ? rdata : 32'h00000000;
      end

      if (apb_wr && word_idx == A_MASK)
      begin
         d.irq_mask = pwdata_in[`IRQ_W-1:0];
      end
      if (apb_wr && word_idx == A_STATUS)
      begin
         clr = pwdata_in[`IRQ_W-1:0];
      end
      if (hit_ctrl && q.state == ST_IDLE)
      begin
         d.gain_dis = pwdata_in[`GAIN_DIS_BIT];
         d.avg_sel = {pwdata_in[`AVG_HI_BIT], pwdata_in[`AVG_LO_BIT]};
         d.cal_arm = pwdata_in[`CAL_ARM_BIT];
         d.cal_type = pwdata_in[`CAL_TYPE_BIT];
      end

      case (q.state)
         ST_IDLE:
         begin
            if (cal_take)
            begin
               d.cal_start = 1'b1;
               d.busy = 1'b1;
               if (pwdata_in[`CAL_TYPE_BIT] && pwdata_in[`GAIN_DIS_BIT])
               begin
                  d.state = ST_FINISH;
               end
               else
               begin
                  d.state = ST_CAL_RUN;
                  d.cal_active = 1'b1;
                  d.ref_sel = pwdata_in[`CAL_TYPE_BIT];
                  d.reads = '0;
                  d.sum = '0;
                  d.conv_req = 1'b1;
               end
            end
            else if (conv_take)
            begin
               d.state = ST_CONV;
               d.busy = 1'b1;
               d.conv_req = 1'b1;
            end
         end
         ST_CONV:
         begin
            if (sar_done)
            begin
               d.result = sar_result;
               d.busy = 1'b0;
               d.state = ST_IDLE;
               ev[`IRQ_CONV_DONE_BIT] = 1'b1;
            end
         end
         ST_CAL_RUN:
         begin
            if (sar_done)
            begin
               d.sum = q.sum + {{(`SUM_WIDTH-`SAR_WIDTH){1'b0}}, sar_result};
               d.reads = q.reads + 6'h01;
               if (d.reads == avg_count(q.avg_sel))
               begin
                  d.state = ST_CAL_DIV;
                  d.steps = '0;
                  d.rem = '0;
               end
               else
               begin
                  d.conv_req = 1'b1;
               end
            end
         end
         ST_CAL_DIV:
         begin
            // restoring divide, one quotient bit per cycle, quotient shifts into sum
            if (rem_sh >= div)
            begin
               d.rem = rem_sh - div;
               qbit = 1'b1;
            end
            else
            begin
               d.rem = rem_sh;
            end
            d.sum = {q.sum[`SUM_WIDTH-2:0], qbit};
            d.steps = q.steps + 5'h01;
            if (q.steps == `DIV_LAST_STEP)
            begin
               d.state = ST_FINISH;
            end
         end
         ST_FINISH:
         begin
            if (q.cal_active)
            begin
               if (q.cal_type)
               begin
                  d.gain_coef = q.sum[`SAR_WIDTH-1:0];
               end
               else
               begin
                  d.offset_coef = q.sum[`SAR_WIDTH-1:0];
               end
            end
            d.cal_active = 1'b0;
            d.cal_start = 1'b0;
            d.busy = 1'b0;
            d.state = ST_IDLE;
            ev[`IRQ_CAL_DONE_BIT] = 1'b1;
         end
         default:
         begin
            d.state = ST_IDLE;
            d.busy = 1'b0;
         end
      endcase

      // a completion in the same cycle as its clear stays set
      d.irq_status = (q.irq_status & ~clr) | ev;
      d.irq = |(d.irq_status & d.irq_mask);
   end

   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign prdata_out = q.prdata;
   assign pready_out = q.pready;
   assign pslverr_out = q.pslverr;
   assign irq_out = q.irq;
   assign ref_sel_out = q.ref_sel;
   assign cal_active_out = q.cal_active;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);

   sequence s_cal_request;
      cal_take;
   endsequence

   sequence s_skip_path;
      q.state == ST_FINISH ##1 (q.state == ST_IDLE && !q.busy && $stable(q.gain_coef));
   endsequence

   property p_busy_follows_start;
      s_cal_request |=> q.busy && q.cal_start;
   endproperty
   a_busy_follows_start: assert property (p_busy_follows_start) else $error("busy late");

   property p_start_clears_at_end;
      $fell(q.cal_start) |-> !q.busy && $past(q.state) == ST_FINISH;
   endproperty
   a_start_clears_at_end: assert property (p_start_clears_at_end) else $error("start clear");

   property p_busy_covers_cycle;
      (q.state != ST_IDLE) |-> q.busy;
   endproperty
   a_busy_covers_cycle: assert property (p_busy_covers_cycle) else $error("busy dropped");

   property p_busy_clears;
      (q.state == ST_CONV && sar_done) |=> !q.busy && q.state == ST_IDLE;
   endproperty
   a_busy_clears: assert property (p_busy_clears) else $error("busy stuck after conversion");

   property p_gain_skip;
      (s_cal_request and (pwdata_in[`CAL_TYPE_BIT] && pwdata_in[`GAIN_DIS_BIT])) |=> s_skip_path;
   endproperty
   a_gain_skip: assert property (p_gain_skip) else $error("gain cal not skipped");

   property p_gain_runs;
      (s_cal_request and (pwdata_in[`CAL_TYPE_BIT] && !pwdata_in[`GAIN_DIS_BIT]))
         |=> q.state == ST_CAL_RUN && q.ref_sel;
   endproperty
   a_gain_runs: assert property (p_gain_runs) else $error("gain cal not run");

   property p_avg_count;
      $rose(q.state == ST_CAL_DIV) |-> q.reads == avg_count(q.avg_sel) ##18 q.state == ST_FINISH;
   endproperty
   a_avg_count: assert property (p_avg_count) else $error("wrong reading count");

   property p_ref_matches_type;
      (q.state == ST_CAL_RUN) |-> q.ref_sel == q.cal_type && q.cal_active;
   endproperty
   a_ref_matches_type: assert property (p_ref_matches_type) else $error("wrong cal ref");

   property p_offset_leaves_gain;
      (q.state == ST_FINISH && !q.cal_type) |=> $stable(q.gain_coef);
   endproperty
   a_offset_leaves_gain: assert property (p_offset_leaves_gain) else $error("gain changed");

   property p_reset_value;
      $past(sys_rst_in) |-> ctrl_byte == `CAL_CTRL_RESET;
   endproperty
   a_reset_value: assert property (p_reset_value) else $error("bad reset value");

endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ns
`include "adc_cal_defines.svh"

module tb_top;
   import adc_cal_pkg::*;

   localparam int unsigned TRK = 2;
   localparam int LIMIT = 60000;
   localparam logic [11:0] A_CAL = {2'b00, `CAL_CTRL_IDX, 2'b00};
   localparam logic [11:0] A_STS = {2'b00, `IRQ_STATUS_IDX, 2'b00};
   localparam logic [11:0] A_MSK = {2'b00, `IRQ_MASK_IDX, 2'b00};
   localparam logic [11:0] A_CONV = {2'b00, `CONV_CTRL_IDX, 2'b00};
   localparam logic [11:0] A_RES = {2'b00, `CONV_RESULT_IDX, 2'b00};
   localparam logic [11:0] A_OFS = {2'b00, `OFFSET_COEF_IDX, 2'b00};
   localparam logic [11:0] A_GN = {2'b00, `GAIN_COEF_IDX, 2'b00};
   localparam logic [32:0] ALL = {33{1'b1}};

   typedef struct packed {logic [32:0] exp; logic [32:0] msk;} note_t;

   logic clock_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0;
   logic cmp_in = 1'b0;
   logic [31:0] prdata_out;
   logic pready_out;
   logic pslverr_out;
   logic irq_out;
   logic track_out;
   logic [11:0] sar_code_out;
   logic ref_sel_out;
   logic cal_active_out;
   note_t notes[$];
   note_t nt;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;
   int tracks = 0;
   int navg[4] = '{15, 1, 31, 63};
   logic track_prev = 1'b0;
   logic ref_seen = 1'b0;
   logic [11:0] vin = 12'h000;
   logic [11:0] gcoef = 12'h000;
   logic [32:0] g;

   // the registered comparator model below costs one more settle cycle per trial
   adc_calibration_control #(.TRACK_CYCLES(TRK), .SETTLE_CYCLES(`SETTLE_CYCLES + 1)) u_dut (
      .clock_in(clock_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .irq_out(irq_out), .cmp_in(cmp_in),
      .track_out(track_out), .sar_code_out(sar_code_out), .ref_sel_out(ref_sel_out),
      .cal_active_out(cal_active_out));

   always #2 clock_in = ~clock_in;

   // ideal comparator: the analog input is the constant vin
   always @(posedge clock_in)
      cmp_in <= (vin >= sar_code_out);

   task automatic wrap_up;
      if (fails == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge clock_in)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         fails++;
         wrap_up();
      end
   end

   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // watch on the falling edge so settled values are seen
   always @(negedge clock_in)
   begin
      if (psel_in && penable_in && pready_out === 1'b1 && !pwrite_in && notes.size() > 0)
      begin
         nt = notes.pop_front();
         check({pslverr_out, prdata_out} & nt.msk, nt.exp & nt.msk);
      end
      if (cal_active_out === 1'b1)
      begin
         ref_seen = ref_sel_out;
         if (track_out === 1'b1 && track_prev !== 1'b1)
            tracks++;
      end
      track_prev = track_out;
   end

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [32:0] got);
      @(posedge clock_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clock_in);
      penable_in <= 1'b1;
      do
         @(posedge clock_in);
      while (pready_out !== 1'b1);
      got = {pslverr_out, prdata_out};
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [32:0] x;
      apb(1'b1, a, d, x);
   endtask

   task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m,
                     output logic [32:0] got);
      notes.push_back('{exp: e, msk: m});
      apb(1'b0, a, 32'h0, got);
   endtask

   task automatic wait_bit(input logic [11:0] a, input int b);
      logic [32:0] x;
      x = ALL;
      while (x[b] !== 1'b0)
         rd(a, 33'h0, 33'h0, x);
   endtask

   task automatic calib(input logic gd, input logic [1:0] av, input logic ty, input int n);
      logic [7:0] cfg;
      logic [32:0] x;
      cfg = {1'b0, gd, av, 1'b0, 1'b1, ty, 1'b0};
      vin = 12'($urandom);
      tracks = 0;
      wr(A_CAL, {24'h0, cfg | 8'h01});
      if (n > 0)
      begin
         rd(A_CAL, {25'h0, cfg | 8'h81}, ALL, x);
         // a changed setup during the run must be refused
         wr(A_CAL, 32'h0000_0045);
      end
      wait_bit(A_CAL, `BUSY_BIT);
      rd(A_CAL, {25'h0, cfg}, ALL, x);
      check(33'(tracks), 33'(n));
      if (n > 0)
      begin
         check({32'h0, ref_seen}, {32'h0, ty});
         rd(ty ? A_GN : A_OFS, {21'h0, vin}, ALL, x);
         if (ty)
            gcoef = vin;
      end
      else
         rd(A_GN, {21'h0, gcoef}, ALL, x);
   endtask

   initial
   begin
      void'($urandom(95));
      repeat (16) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      rd(A_CAL, 33'h0, ALL, g);
      rd(A_STS, 33'h0, ALL, g);
      rd(A_MSK, 33'h0, ALL, g);
      rd(12'h000, {1'b1, 32'h0}, ALL, g);
      wr(A_MSK, 32'h1);
      for (int c = 0; c < 4; c++)
         calib(1'($urandom), 2'(c), 1'b0, navg[c]);
      @(negedge clock_in);
      check({32'h0, irq_out}, 33'h1);
      rd(A_STS, 33'h1, 33'h1, g);
      wr(A_STS, 32'h1);
      repeat (2) @(negedge clock_in);
      check({32'h0, irq_out}, 33'h0);
      calib(1'b0, 2'b01, 1'b1, 1);
      calib(1'b1, 2'b00, 1'b1, 0);
      wr(A_STS, 32'h3);
      wr(A_MSK, 32'h0);
      calib(1'b1, 2'b11, 1'b1, 0);
      repeat (2) @(negedge clock_in);
      check({32'h0, irq_out}, 33'h0);
      rd(A_STS, 33'h1, 33'h1, g);
      wr(A_MSK, 32'h3);
      repeat (2) @(negedge clock_in);
      check({32'h0, irq_out}, 33'h1);
      wr(A_STS, 32'h1);
      // single conversion: busy shows, result latched, done status
      vin = 12'($urandom);
      wr(A_CONV, 32'h1);
      rd(A_CAL, 33'h80, 33'h80, g);
      wait_bit(A_CONV, `CONV_START_BIT);
      rd(A_RES, {21'h0, vin}, ALL, g);
      rd(A_STS, 33'h2, ALL, g);
      rd(A_CAL, 33'h0, 33'h80, g);
      @(negedge clock_in);
      check({32'h0, irq_out}, 33'h1);
      wrap_up();
   end
endmodule
